//--- src/hpia_defs.svh
// constants of the host port indirect access block
`ifndef HPIA_DEFS_SVH
`define HPIA_DEFS_SVH
`define HPIA_ADR_DATA_LOW   3'h0
`define HPIA_ADR_DATA_MID   3'h1
`define HPIA_ADR_DATA_TOP   3'h2
`define HPIA_ADR_SLEEP      3'h3
`define HPIA_ADR_PIN_SYNC   3'h4
`define HPIA_ADR_SOFT_SYNC  3'h5
`define HPIA_ADR_ADDR_LOW   3'h6
`define HPIA_ADR_TARGET     3'h7
`define HPIA_ACR_AUTOINC    7
`define HPIA_ACR_BCAST      6
`define HPIA_SLP_IOMAP      5
`define HPIA_PS_FIRST_ONLY  6
`define HPIA_PS_TOGGLE_IEN  7
`define HPIA_SS_TEST_SEL    6
`define HPIA_SS_PN_SEL      7
`define HPIA_INS_ALL        4'h0
`define HPIA_INS_CH012      4'h1
`define HPIA_INS_CH123      4'h2
`define HPIA_INS_ONE_CH     4'h4
`define HPIA_REG_RESET      8'h00
`define HPIA_NEG_FULL_SCALE 20'h80000
`define HPIA_PN_SEED        20'h00001
`endif

//--- src/hpia_pkg.sv
// types of the host port indirect access block
package hpia_pkg;
    typedef enum logic [1:0] {HPIA_IDLE, HPIA_WAIT_REL} hpia_state_t;
endpackage : hpia_pkg

//--- src/hpia_top.sv
// host microport register set with indirect internal access
//
// Contract
// - broadcast with instruction 0000 hits every chip and every channel.
// - broadcast 0001 hits channels 0..2, 0010 hits channels 1..3.
// - broadcast 0100 hits every chip, one channel from upper address bits.
// - broadcast 1000/1001 match identity bit 0; 11xx match identity bits 1:0.
// - access control bits 1:0 pick the channel unless multiple channels targeted.
// - readback invalid while broadcast high; host clears broadcast before reads.
// - address low register increments after each data low access when auto-increment set.
// - a one in soft sync bits 3..0 syncs channels watching that bit.
// - soft sync bit 4 adds chip start, bit 5 adds oscillator hop.
// - soft sync bit 6 selects test data; bit 7 picks random or negative full scale.
// - pin sync enables let the sync pin sync channels watching that position.
// - pin sync bit 4 starts chip, bit 5 hops oscillator on sync pulse.
// - pin sync bit 6 clear acts on every pulse; set acts on first only.
// - pin sync bit 7 toggles input enable internally to emulate multiplexed converter.
// - sleep bits 3..0 put matching channel into low power sleep.
// - sleep bit 5 makes the address index the input/output control map.
// - data low write moves up to 20 bits to the 10-bit internal address.
// - data low read launches internal read and returns low byte first.
// - data top register keeps four bits; upper bits dropped and read zero.
// - consecutive accesses accepted while chip select stays low, one per strobe.
// - bus mode low gives separate strobes, high gives data strobe with direction.
// - without broadcast, data low accesses act only when instruction equals the identity pins; other registers always accept.
// - access control at address 111: autoinc 7, broadcast 6, instr 5:2, addr 1:0.
`timescale 1ns/10ps
`include "hpia_defs.svh"
module hpia_top
(
    input  wire logic        CLK,
    input  wire logic        RESET_N,
    input  wire logic        CLK_EN,
    input  wire logic        MODE,
    input  wire logic        CS_N,
    input  wire logic        RD_N,
    input  wire logic        WR_N,
    input  wire logic [2:0]  ADDR,
    input  wire logic [7:0]  DATA_IN,
    output logic      [7:0]  DATA_OUT,
    output logic             DATA_OE,
    output logic             READY,
    input  wire logic [3:0]  CHIP_IDENTITY_PINS,
    input  wire logic        SYNC_PIN,
    output logic      [9:0]  INT_ADDR,
    output logic      [19:0] INT_WDATA,
    output logic             INT_WR,
    output logic             INT_RD,
    output logic      [3:0]  INT_CH_SEL,
    output logic             INT_IOMAP,
    input  wire logic [19:0] INT_RDATA,
    input  wire logic        INT_RVALID,
    input  wire logic [3:0]  ADC_DATA_IN,
    output logic      [19:0] TEST_DATA,
    output logic             TEST_SEL,
    output logic             INPUT_ENABLE_PIN,
    output logic      [3:0]  SYNC_POS,
    output logic             CHIP_START,
    output logic             OSC_HOP,
    output logic      [3:0]  CH_SLEEP
);
    // ------------------------------------------------------------
    // registers and pin synchronisers
    // ------------------------------------------------------------
    logic [7:0]  target_q;
    logic [7:0]  addr_low_q;
    logic [7:0]  soft_sync_q;
    logic [7:0]  pin_sync_q;
    logic [7:0]  sleep_q;
    logic [7:0]  data_low_q;
    logic [7:0]  data_mid_q;
    logic [3:0]  data_top_q;
    logic [2:0]  rs_q;
    logic [2:0]  ws_q;
    logic [2:0]  cs_q;
    logic [2:0]  sp_q;
    logic        first_seen_q;
    logic        ien_q;
    logic [19:0] pn_q;
    hpia_pkg::hpia_state_t state_q;

    // decide chip hit and channel set for the current instruction
    function automatic logic [4:0] hpia_decode
    (
        input logic [7:0] access_target_ctrl,
        input logic [3:0] id
    );
        logic [3:0] ins;
        logic [3:0] one;
        logic       hit;
        logic [3:0] chs;
        ins = access_target_ctrl[5:2];
        one = 4'h1 << access_target_ctrl[1:0];
        hit = 1'b0;
        chs = one;
        if (!access_target_ctrl[`HPIA_ACR_BCAST])
            hit = (ins == id);
        else
        begin
            case (ins)
                `HPIA_INS_ALL:    begin hit = 1'b1; chs = 4'hf; end
                `HPIA_INS_CH012:  begin hit = 1'b1; chs = 4'h7; end
                `HPIA_INS_CH123:  begin hit = 1'b1; chs = 4'he; end
                `HPIA_INS_ONE_CH: hit = 1'b1;
                4'h8, 4'h9:       hit = (id[0] == ins[0]);
                4'hc, 4'hd, 4'he, 4'hf: hit = (id[1:0] == ins[1:0]);
                default:          hit = 1'b0;
            endcase
        end
        return {hit, chs};
    endfunction : hpia_decode

    // pins cross into clk domain through three flops
    always_ff @(posedge CLK)
    begin
        if (!RESET_N)
        begin
            rs_q <= 3'h7;
            ws_q <= 3'h7;
            cs_q <= 3'h7;
            sp_q <= 3'h0;
        end
        else if (CLK_EN)
        begin
            rs_q <= {rs_q[1:0], RD_N};
            ws_q <= {ws_q[1:0], WR_N};
            cs_q <= {cs_q[1:0], CS_N};
            sp_q <= {sp_q[1:0], SYNC_PIN};
        end
    end

    // ------------------------------------------------------------
    // strobe decode for both bus modes
    // ------------------------------------------------------------
    logic       rd_lvl;
    logic       wr_lvl;
    logic       rd_go;
    logic       wr_go;
    logic       sel_ok;
    logic [4:0] dec;
    logic       stable;
    logic       strobe_on;

    // stable only when second and third stages agree
    assign stable    = (rs_q[1] == rs_q[2]) && (ws_q[1] == ws_q[2]) && (cs_q[1] == cs_q[2]);
    // motorola: data strobe on rd pin, direction on wr pin
    assign rd_lvl    = MODE ? (!rs_q[2] && ws_q[2]) : !rs_q[2];
    assign wr_lvl    = MODE ? (!rs_q[2] && !ws_q[2]) : !ws_q[2];
    assign strobe_on = stable && !cs_q[2] && (rd_lvl || wr_lvl);
    assign dec       = hpia_decode(target_q, CHIP_IDENTITY_PINS);
    // every register but data low is always reachable; data low hits need decode
    assign sel_ok    = dec[4] || (ADDR != `HPIA_ADR_DATA_LOW);
    assign rd_go     = CLK_EN && state_q == hpia_pkg::HPIA_IDLE && strobe_on && rd_lvl;
    assign wr_go     = CLK_EN && state_q == hpia_pkg::HPIA_IDLE && strobe_on && wr_lvl;

    // one access per strobe: wait for release before the next
    always_ff @(posedge CLK)
    begin
        if (!RESET_N)
            state_q <= hpia_pkg::HPIA_IDLE;
        else if (CLK_EN)
        begin
            case (state_q)
                hpia_pkg::HPIA_IDLE:
                    if (strobe_on)
                        state_q <= hpia_pkg::HPIA_WAIT_REL;
                hpia_pkg::HPIA_WAIT_REL:
                    if (stable && (cs_q[2] || !(rd_lvl || wr_lvl)))
                        state_q <= hpia_pkg::HPIA_IDLE;
                default:
                    state_q <= hpia_pkg::HPIA_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    always_ff @(posedge CLK)
    begin
        if (!RESET_N)
        begin
            target_q    <= `HPIA_REG_RESET;
            soft_sync_q <= `HPIA_REG_RESET;
            pin_sync_q  <= `HPIA_REG_RESET;
            sleep_q     <= `HPIA_REG_RESET;
        end
        else if (wr_go)
        begin
            case (ADDR)
                `HPIA_ADR_TARGET:    target_q    <= DATA_IN;
                `HPIA_ADR_SOFT_SYNC: soft_sync_q <= DATA_IN;
                `HPIA_ADR_PIN_SYNC:  pin_sync_q  <= DATA_IN;
                `HPIA_ADR_SLEEP:     sleep_q     <= DATA_IN;
                default:             ;
            endcase
        end
    end

    // address low register with auto increment after data low access
    always_ff @(posedge CLK)
    begin
        if (!RESET_N)
            addr_low_q <= `HPIA_REG_RESET;
        else if (wr_go && ADDR == `HPIA_ADR_ADDR_LOW)
            addr_low_q <= DATA_IN;
        else if ((wr_go || rd_go) && ADDR == `HPIA_ADR_DATA_LOW && dec[4] && target_q[`HPIA_ACR_AUTOINC])
            addr_low_q <= addr_low_q + 8'h01;
    end

    // data holding registers; top keeps four bits only
    always_ff @(posedge CLK)
    begin
        if (!RESET_N)
        begin
            data_low_q <= `HPIA_REG_RESET;
            data_mid_q <= `HPIA_REG_RESET;
            data_top_q <= 4'h0;
        end
        else if (CLK_EN && INT_RVALID)
        begin
            data_low_q <= INT_RDATA[7:0];
            data_mid_q <= INT_RDATA[15:8];
            data_top_q <= INT_RDATA[19:16];
        end
        else if (wr_go)
        begin
            case (ADDR)
                `HPIA_ADR_DATA_LOW: if (dec[4]) data_low_q <= DATA_IN;
                `HPIA_ADR_DATA_MID: data_mid_q <= DATA_IN;
                `HPIA_ADR_DATA_TOP: data_top_q <= DATA_IN[3:0];
                default:            ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // internal access launch
    // ------------------------------------------------------------
    always_ff @(posedge CLK)
    begin
        if (!RESET_N)
        begin
            INT_WR     <= 1'b0;
            INT_RD     <= 1'b0;
            INT_ADDR   <= 10'h000;
            INT_WDATA  <= 20'h00000;
            INT_CH_SEL <= 4'h0;
            INT_IOMAP  <= 1'b0;
        end
        else if (CLK_EN)
        begin
            // low byte write is the trigger, so high bytes must already stand
            INT_WR <= wr_go && ADDR == `HPIA_ADR_DATA_LOW && dec[4];
            INT_RD <= rd_go && ADDR == `HPIA_ADR_DATA_LOW && dec[4];
            if ((wr_go || rd_go) && ADDR == `HPIA_ADR_DATA_LOW && dec[4])
            begin
                INT_ADDR   <= {target_q[1:0], addr_low_q};
                INT_WDATA  <= {data_top_q, data_mid_q, DATA_IN};
                INT_CH_SEL <= dec[3:0];
                INT_IOMAP  <= sleep_q[`HPIA_SLP_IOMAP];
            end
        end
    end

    // ------------------------------------------------------------
    // read path and ready
    // ------------------------------------------------------------
    always_ff @(posedge CLK)
    begin
        if (!RESET_N)
        begin
            DATA_OUT <= 8'h00;
            DATA_OE  <= 1'b0;
            READY    <= 1'b1;
        end
        else if (CLK_EN)
        begin
            if (rd_go && sel_ok)
            begin
                DATA_OE <= !target_q[`HPIA_ACR_BCAST];
                case (ADDR)
                    `HPIA_ADR_DATA_LOW: DATA_OUT <= INT_RVALID ? INT_RDATA[7:0] : data_low_q;
                    `HPIA_ADR_DATA_MID: DATA_OUT <= data_mid_q;
                    `HPIA_ADR_DATA_TOP: DATA_OUT <= {4'h0, data_top_q};
                    `HPIA_ADR_ADDR_LOW: DATA_OUT <= addr_low_q;
                    `HPIA_ADR_TARGET:   DATA_OUT <= target_q;
                    default:            DATA_OUT <= 8'h00;            // write-only
                endcase
            end
            else if (state_q == hpia_pkg::HPIA_IDLE)
                DATA_OE <= 1'b0;
            // internal read answers after the take, so refresh the low byte
            if (INT_RVALID && state_q == hpia_pkg::HPIA_WAIT_REL)
                DATA_OUT <= INT_RDATA[7:0];
            READY <= !(strobe_on && state_q == hpia_pkg::HPIA_IDLE);
        end
    end

    // ------------------------------------------------------------
    // sync, start, hop, sleep
    // ------------------------------------------------------------
    logic pin_pulse;
    logic sp_prev_q;
    // rising edge of the settled pin; prev resets low like the idle pin
    assign pin_pulse = CLK_EN && (sp_q[1] == sp_q[2]) && sp_q[2] && !sp_prev_q;

    always_ff @(posedge CLK)
    begin
        if (!RESET_N)
        begin
            sp_prev_q    <= 1'b0;
            first_seen_q <= 1'b0;
        end
        else if (CLK_EN)
        begin
            if (sp_q[1] == sp_q[2])
                sp_prev_q <= sp_q[2];
            if (wr_go && ADDR == `HPIA_ADR_PIN_SYNC)
                first_seen_q <= 1'b0;                                // re-arm on write
            if (pin_pulse)
                first_seen_q <= 1'b1;
        end
    end

    logic pin_act;
    logic soft_act;
    assign pin_act  = pin_pulse && !(pin_sync_q[`HPIA_PS_FIRST_ONLY] && first_seen_q);
    assign soft_act = wr_go && ADDR == `HPIA_ADR_SOFT_SYNC && (DATA_IN[3:0] != 4'h0);

    always_ff @(posedge CLK)
    begin
        if (!RESET_N)
        begin
            SYNC_POS   <= 4'h0;
            CHIP_START <= 1'b0;
            OSC_HOP    <= 1'b0;
            CH_SLEEP   <= 4'h0;
        end
        else if (CLK_EN)
        begin
            CH_SLEEP <= sleep_q[3:0];
            if (soft_act)
            begin
                SYNC_POS   <= DATA_IN[3:0];
                CHIP_START <= DATA_IN[4];
                OSC_HOP    <= DATA_IN[5];
            end
            else if (pin_act)
            begin
                SYNC_POS   <= pin_sync_q[3:0];
                CHIP_START <= pin_sync_q[4];
                OSC_HOP    <= pin_sync_q[5];
            end
            else
            begin
                SYNC_POS   <= 4'h0;
                CHIP_START <= 1'b0;
                OSC_HOP    <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // test data injection
    // ------------------------------------------------------------
    always_ff @(posedge CLK)
    begin
        if (!RESET_N)
        begin
            pn_q             <= `HPIA_PN_SEED;
            ien_q            <= 1'b1;
            TEST_DATA        <= 20'h00000;
            TEST_SEL         <= 1'b0;
            INPUT_ENABLE_PIN <= 1'b1;
        end
        else if (CLK_EN)
        begin
            pn_q     <= {pn_q[18:0], pn_q[19] ^ pn_q[16]};
            TEST_SEL <= soft_sync_q[`HPIA_SS_TEST_SEL];
            if (!soft_sync_q[`HPIA_SS_TEST_SEL])
                TEST_DATA <= {16'h0000, ADC_DATA_IN};
            else if (soft_sync_q[`HPIA_SS_PN_SEL])
                TEST_DATA <= pn_q;
            else
                TEST_DATA <= `HPIA_NEG_FULL_SCALE;
            // toggling mimics a two-channel multiplexed converter
            ien_q            <= pin_sync_q[`HPIA_PS_TOGGLE_IEN] ? !ien_q : 1'b1;
            INPUT_ENABLE_PIN <= ien_q;
        end
    end

endmodule : hpia_top

//--- tb/hpia_properties.sv
// concurrent checks on the host port and internal access outputs
`timescale 1ns/10ps
module hpia_properties
(
    input  wire logic       CLK,
    input  wire logic       RESET_N,
    input  wire logic       CS_N,
    input  wire logic       RD_N,
    input  wire logic       WR_N,
    input  wire logic       DATA_OE,
    input  wire logic       INT_WR,
    input  wire logic       INT_RD,
    input  wire logic [3:0] INT_CH_SEL,
    input  wire logic       CHIP_START,
    input  wire logic       OSC_HOP,
    input  wire logic [3:0] SYNC_POS,
    input  wire logic       READY
);
    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RESET_N);

    // internal strobes only follow a pin strobe seen through the synchroniser
    a_wr_needs_strobe: assert property (INT_WR |-> !$past(CS_N, 3) && !$past(WR_N, 3))
        else $error("internal write without a write strobe");
    a_rd_needs_strobe: assert property (INT_RD |-> !$past(CS_N, 3) && !$past(RD_N, 3) && $past(WR_N, 3))
        else $error("internal read without a read strobe");
    a_one_kind_only: assert property (!(INT_WR && INT_RD))
        else $error("internal read and write together");
    a_ch_sel_legal: assert property (INT_WR |-> INT_CH_SEL inside {4'hf, 4'h7, 4'he, 4'h1, 4'h2, 4'h4, 4'h8})
        else $error("channel select outside the decode table");
    a_oe_on_reads: assert property (DATA_OE |-> $past(WR_N, 3))
        else $error("data bus driven during a write");
    // sync outputs are single-cycle events
    a_start_pulse: assert property (CHIP_START |=> !CHIP_START)
        else $error("chip start held");
    a_hop_pulse: assert property (OSC_HOP |=> !OSC_HOP)
        else $error("oscillator hop held");
    a_sync_pulse: assert property ((SYNC_POS != 4'h0) |=> (SYNC_POS == 4'h0))
        else $error("sync position held");
    // the take that launches an internal access also pulls ready low
    a_ready_on_take: assert property ((INT_WR || INT_RD) |-> !READY)
        else $error("internal access without ready low");

    cover property (INT_WR && INT_CH_SEL == 4'hf);
    cover property (INT_RD);
    cover property (CHIP_START && OSC_HOP);
endmodule : hpia_properties

bind hpia_top hpia_properties chk_i
(
    .CLK(CLK), .RESET_N(RESET_N), .CS_N(CS_N), .RD_N(RD_N), .WR_N(WR_N), .DATA_OE(DATA_OE),
    .INT_WR(INT_WR), .INT_RD(INT_RD), .INT_CH_SEL(INT_CH_SEL), .CHIP_START(CHIP_START),
    .OSC_HOP(OSC_HOP), .SYNC_POS(SYNC_POS), .READY(READY)
);

//--- tb/hpia_host.sv
// host processor model on the 8-bit parallel port
`timescale 1ns/10ps
module hpia_host
(
    output logic            CS_N,
    output logic            RD_N,
    output logic            WR_N,
    output logic [2:0]      ADDR,
    output logic [7:0]      DATA_IN,
    input  wire logic       CLK,
    input  wire logic       MODE,
    input  wire logic [7:0] DATA_OUT,
    input  wire logic       DATA_OE,
    input  wire logic       READY
);
    // ----------------------------------------
    // bus cycles
    // ----------------------------------------
    initial
    begin
        CS_N = 1'h1;
        RD_N = 1'h1;
        WR_N = 1'h1;
        ADDR = 3'h0;
        DATA_IN = 8'h00;
    end

    // one strobe per access; wr pin is the write strobe in mode low and the direction in mode high
    task automatic access(input logic w, input logic [2:0] a, input logic [7:0] d,
                          output logic [7:0] q, output logic oe);
        int n;
        n = 0;
        @(posedge CLK);
        CS_N <= 1'h0;
        ADDR <= a;
        DATA_IN <= d;
        RD_N <= MODE ? 1'h0 : w;
        WR_N <= ~w;
        do
        begin
            @(posedge CLK);
            n++;
        end
        while (READY !== 1'h0 && n < 20);
        // keep the strobe well past the take so the answer has settled
        repeat (4) @(posedge CLK);
        q = DATA_OUT;
        oe = DATA_OE;
        CS_N <= 1'h1;
        RD_N <= 1'h1;
        WR_N <= 1'h1;
        DATA_IN <= ~d; // released data never shows the old byte
        repeat (8) @(posedge CLK);
    endtask : access
endmodule : hpia_host

//--- tb/hpia_bench.sv
// self-checking bench for the host port indirect access block
`timescale 1ns/10ps
module hpia_bench;
    logic        CLK, RESET_N, CLK_EN, MODE, CS_N, RD_N, WR_N, SYNC_PIN, INT_RVALID, DATA_OE, READY;
    logic        INT_WR, INT_RD, INT_IOMAP, TEST_SEL, INPUT_ENABLE_PIN, CHIP_START, OSC_HOP, c_iomap;
    logic        s_start, s_hop, ien_q;
    logic [2:0]  ADDR;
    logic [3:0]  CHIP_IDENTITY_PINS, INT_CH_SEL, ADC_DATA_IN, SYNC_POS, CH_SLEEP, c_sel, s_pos;
    logic [7:0]  DATA_IN, DATA_OUT;
    logic [9:0]  INT_ADDR, c_addr;
    logic [19:0] INT_WDATA, INT_RDATA, TEST_DATA, c_wdata;
    logic [31:0] seed;
    int          errors, n_compared, n_wr, n_rd, n_ien;
    localparam logic [3:0] INS [10] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8, 4'h9, 4'hc, 4'hd, 4'he, 4'hf};

    hpia_top dut
    (
        .CLK(CLK), .RESET_N(RESET_N), .CLK_EN(CLK_EN), .MODE(MODE), .CS_N(CS_N), .RD_N(RD_N), .WR_N(WR_N),
        .ADDR(ADDR), .DATA_IN(DATA_IN), .DATA_OUT(DATA_OUT), .DATA_OE(DATA_OE), .READY(READY),
        .CHIP_IDENTITY_PINS(CHIP_IDENTITY_PINS), .SYNC_PIN(SYNC_PIN), .INT_ADDR(INT_ADDR),
        .INT_WDATA(INT_WDATA), .INT_WR(INT_WR), .INT_RD(INT_RD), .INT_CH_SEL(INT_CH_SEL),
        .INT_IOMAP(INT_IOMAP), .INT_RDATA(INT_RDATA), .INT_RVALID(INT_RVALID), .ADC_DATA_IN(ADC_DATA_IN),
        .TEST_DATA(TEST_DATA), .TEST_SEL(TEST_SEL), .INPUT_ENABLE_PIN(INPUT_ENABLE_PIN),
        .SYNC_POS(SYNC_POS), .CHIP_START(CHIP_START), .OSC_HOP(OSC_HOP), .CH_SLEEP(CH_SLEEP)
    );
    hpia_host host
    (
        .CS_N(CS_N), .RD_N(RD_N), .WR_N(WR_N), .ADDR(ADDR), .DATA_IN(DATA_IN), .CLK(CLK), .MODE(MODE),
        .DATA_OUT(DATA_OUT), .DATA_OE(DATA_OE), .READY(READY)
    );

    // ----------------------------------------
    // models and helpers
    // ----------------------------------------
    always #4 CLK = ~CLK;

    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : lfsr

    function automatic logic [19:0] rdat(input logic [9:0] a);
        return {a, a ^ 10'h2b5};
    endfunction : rdat

    // channels hit by an access for a given target control byte and identity
    function automatic logic [3:0] sel_of(input logic [7:0] access_target_ctrl, input logic [3:0] id);
        logic [3:0] one;
        one = 4'h1 << access_target_ctrl[1:0];
        if (!access_target_ctrl[6])
            return (access_target_ctrl[5:2] == id) ? one : 4'h0;
        case (access_target_ctrl[5:2])
            4'h0: return 4'hf;
            4'h1: return 4'h7;
            4'h2: return 4'he;
            4'h4: return one;
            4'h8, 4'h9: return (access_target_ctrl[2] == id[0]) ? one : 4'h0;
            default: return (access_target_ctrl[3:2] == id[1:0]) ? one : 4'h0;
        endcase
    endfunction : sel_of

    // internal side answers a read on the next edge, scrambles the bus otherwise
    always @(posedge CLK)
    begin
        INT_RVALID <= INT_RD;
        INT_RDATA <= INT_RD ? rdat(INT_ADDR) : ~INT_RDATA;
        ADC_DATA_IN <= seed[3:0];
    end

    // capture of internal strobes and pulse outputs between clears
    always @(posedge CLK)
    begin
        if (INT_WR === 1'h1)
        begin
            n_wr++;
            c_sel = INT_CH_SEL;
            c_addr = INT_ADDR;
            c_wdata = INT_WDATA;
            c_iomap = INT_IOMAP;
        end
        n_rd += (INT_RD === 1'h1);
        n_ien += (INPUT_ENABLE_PIN !== ien_q);
        ien_q = INPUT_ENABLE_PIN;
        s_pos |= SYNC_POS;
        s_start |= CHIP_START;
        s_hop |= OSC_HOP;
    end

    task automatic clr;
        #1;
        n_wr = 0;
        n_rd = 0;
        n_ien = 0;
        s_pos = 4'h0;
        s_start = 1'h0;
        s_hop = 1'h0;
    endtask : clr

    task automatic chk(input string nm, input logic [19:0] seen, input logic [19:0] want);
        n_compared++;
        if (seen !== want)
        begin
            errors++;
            $display("[ERR] %s expected %h seen %h", nm, want, seen);
        end
    endtask : chk

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        logic [7:0] q;
        logic       oe;
        host.access(1'h1, a, d, q, oe);
    endtask : wr

    task automatic rd(input logic [2:0] a, output logic [7:0] q, output logic oe);
        host.access(1'h0, a, 8'h00, q, oe);
    endtask : rd

    task automatic sync_pulse;
        @(posedge CLK);
        SYNC_PIN <= 1'h1;
        repeat (4) @(posedge CLK);
        SYNC_PIN <= 1'h0;
        repeat (8) @(posedge CLK);
    endtask : sync_pulse

    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : end_sim

    // ----------------------------------------
    // tests
    // ----------------------------------------
    // about 300 cycles per pass; a hang is cut well beyond that
    initial
    begin
        repeat (20000) @(posedge CLK);
        errors++;
        end_sim;
    end

    initial
    begin : main
        logic [7:0]  access_target_ctrl, internal_address_low, s, p, q;
        logic [19:0] d;
        logic [3:0]  exp;
        logic        oe;
        CLK = 1'h0;
        RESET_N = 1'h0;
        CLK_EN = 1'h1;
        MODE = 1'h0;
        SYNC_PIN = 1'h0;
        CHIP_IDENTITY_PINS = 4'h0;
        INT_RDATA = 20'h00000;
        INT_RVALID = 1'h0;
        ADC_DATA_IN = 4'h0;
        seed = 32'ha903;
        repeat (2) @(posedge CLK);
        RESET_N <= 1'h1;
        for (int i = 0; i < 22; i++)
        begin
            repeat (32) seed = lfsr(seed);
            @(posedge CLK);
            MODE <= i[0];
            CHIP_IDENTITY_PINS <= seed[3:0];
            access_target_ctrl = {seed[7], i < 20, i < 20 ? INS[i / 2] : (i == 20 ? seed[3:0] : ~seed[3:0]), seed[5:4]};
            internal_address_low = seed[23:16];
            s = seed[15:8] | 8'h01;
            p = seed[31:24] | 8'h01;
            wr(3'h3, seed[31:24] & 8'h2f);
            chk("sleep", CH_SLEEP, seed[27:24]);
            // clock enable low: a full write to the sleep register must leave it frozen
            if (i == 3)
            begin
                CLK_EN <= 1'h0;
                wr(3'h3, {4'h0, ~seed[27:24]});
                CLK_EN <= 1'h1;
                chk("frozen", CH_SLEEP, seed[27:24]);
            end
            clr;
            wr(3'h5, s);
            chk("soft_pos", s_pos, s[3:0]);
            chk("soft_start", s_start, s[4]);
            chk("soft_hop", s_hop, s[5]);
            chk("test_sel", TEST_SEL, s[6]);
            if (s[7:6] == 2'h1)
                chk("test_data", TEST_DATA, 20'h80000);
            if (!s[6])
                chk("adc_data", TEST_DATA, {16'h0000, seed[3:0]});
            wr(3'h4, p);
            clr;
            sync_pulse;
            chk("pin_pos", s_pos, p[3:0]);
            chk("pin_start", s_start, p[4]);
            chk("pin_hop", s_hop, p[5]);
            clr;
            sync_pulse;
            chk("pin_again", s_pos, p[6] ? 4'h0 : p[3:0]);
            if (s[6] || !p[7])
                chk("ien_toggle", n_ien != 0, p[7]);
            wr(3'h7, access_target_ctrl);
            wr(3'h6, internal_address_low);
            wr(3'h2, seed[31:24]);
            wr(3'h1, seed[15:8]);
            clr;
            wr(3'h0, seed[7:0]);
            exp = sel_of(access_target_ctrl, seed[3:0]);
            chk("wr_count", n_wr, exp != 4'h0);
            if (exp != 4'h0)
            begin
                chk("ch_sel", c_sel, exp);
                chk("int_addr", c_addr, {access_target_ctrl[1:0], internal_address_low});
                chk("int_wdata", c_wdata, {seed[27:24], seed[15:8], seed[7:0]});
                chk("iomap", c_iomap, seed[29]);
            end
            // broadcast cleared and identity matched before the reads up to rd_top
            wr(3'h7, {2'h0, seed[3:0], access_target_ctrl[1:0]});
            rd(3'h6, q, oe);
            chk("addr_low", q, 8'(internal_address_low + {7'h00, exp != 4'h0 && access_target_ctrl[7]}));
            d = rdat({access_target_ctrl[1:0], q});
            clr;
            rd(3'h0, q, oe);
            chk("rd_oe", oe, 1'h1);
            chk("rd_low", q, d[7:0]);
            chk("rd_count", n_rd, 1);
            rd(3'h1, q, oe);
            chk("rd_mid", q, d[15:8]);
            rd(3'h2, q, oe);
            chk("rd_top", q, {4'h0, d[19:16]});
            wr(3'h7, access_target_ctrl);
            rd(3'h0, q, oe);
            chk("oe_again", oe, !access_target_ctrl[6] && exp != 4'h0);
        end
        end_sim;
    end
endmodule : hpia_bench
